// ==== hdl/rcbc_pkg.sv ====
package rcbc_pkg;

    localparam int          ADDR_W    = 14;
    localparam int          NUM_FLAGS = 10;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_BROWNOUT_CONTROL = 12'hedb;
    localparam logic [11:0] IDX_CAUSE_SECONDARY  = 12'hfd6;
    localparam logic [11:0] IDX_CAUSE_MAIN       = 12'hfd7;
    localparam logic [11:0] IDX_IRQ_STATUS       = 12'hee0;
    localparam logic [11:0] IDX_IRQ_MASK         = 12'hee1;

    // brown-out control fields
    localparam int          SOFT_ENABLE_POS = 7;
    localparam int          READY_POS       = 0;
    localparam logic [1:0]  CONFIG_SOFT     = 2'h1;
    localparam logic        SOFT_ENABLE_RST = 1'b1;

    // flag vector positions: 7..0 main register, 8..9 secondary
    localparam int          F_BROWNOUT   = 0;
    localparam int          F_POWER_ON   = 1;
    localparam int          F_RESET_INSN = 2;
    localparam int          F_EXT_PIN    = 3;
    localparam int          F_WDT_TMO    = 4;
    localparam int          F_WINDOW     = 5;
    localparam int          F_STK_UNF    = 6;
    localparam int          F_STK_OVF    = 7;
    localparam int          F_REGULATOR  = 8;
    localparam int          F_CFG_LATCH  = 9;

    // positions inside the secondary register
    localparam int          SEC_REGULATOR_POS = 2;
    localparam int          SEC_CFG_LATCH_POS = 0;

    // active value of each flag, and values loaded on power-on/brown-out
    localparam logic [9:0]  FLAG_ACTIVE   = 10'h2c0;
    localparam logic [9:0]  FLAG_POR_VAL  = 10'h33d;
    localparam logic [9:0]  FLAG_BOR_VAL  = 10'h33c;
    localparam logic [9:0]  FLAG_BOR_KEEP = 10'h002;
    localparam logic [9:0]  IRQ_MASK_RST  = 10'h000;
    localparam logic [9:0]  IRQ_STAT_RST  = 10'h000;

    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [11:0]       idx);
        return addr == {idx, 2'b00};
    endfunction

endpackage

// ==== hdl/rcbc_pin_sync.sv ====
`timescale 1ns/1ns
module rcbc_pin_sync #(
    parameter logic IDLE = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // a change counts once the second and third stages agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1    <= IDLE;
            s2    <= IDLE;
            s3    <= IDLE;
            level <= IDLE;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // rcbc_pin_sync

// ==== hdl/rcbc_cause_flag.sv ====
`timescale 1ns/1ns
module rcbc_cause_flag #(
    parameter logic ACTIVE    = 1'b0,
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic init_en,
    input  wire logic init_val,
    input  wire logic hw_evt,
    input  wire logic wr_en,
    input  wire logic wr_val,
    output logic      flag
);
    logic next_flag;

    // power-up load first, then hardware cause, then firmware write
    assign next_flag = init_en ? init_val :
                       hw_evt  ? ACTIVE   :
                       wr_en   ? wr_val   : flag;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag <= RESET_VAL;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // rcbc_cause_flag

// ==== hdl/rcbc_reset_cause.sv ====
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module rcbc_reset_cause
(
    input  wire logic                       CLK,
    input  wire logic                       RST_N,
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [rcbc_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [31:0]                PWDATA,
    input  wire logic [3:0]                 PSTRB,
    output logic      [31:0]                PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    input  wire logic                       POR_EVT,
    input  wire logic                       BOR_EVT,
    input  wire logic                       EXTERNAL_RESET_PIN_N,
    input  wire logic                       WATCHDOG_TIMEOUT_EVT,
    input  wire logic                       WINDOW_VIOLATION_EVT,
    input  wire logic                       RESET_INSTRUCTION_EVT,
    input  wire logic                       STACK_OVERFLOW_EVT,
    input  wire logic                       STACK_UNDERFLOW_EVT,
    input  wire logic                       REGULATOR_FAULT_EVT,
    input  wire logic                       CONFIG_LATCH_EVT,
    input  wire logic [1:0]                 BROWNOUT_CONFIG_FIELD,
    input  wire logic                       BROWNOUT_CIRCUIT_ARMED,
    output logic                            BROWNOUT_RESET_ENABLE,
    output logic                            IRQ
);
    import rcbc_pkg::*;

    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] hw_evt;
    logic [NUM_FLAGS-1:0] irq_evt;
    logic [NUM_FLAGS-1:0] init_en;
    logic [NUM_FLAGS-1:0] init_val;
    logic [NUM_FLAGS-1:0] wr_en;
    logic [NUM_FLAGS-1:0] wr_val;
    logic [NUM_FLAGS-1:0] irq_status;
    logic [NUM_FLAGS-1:0] irq_mask;
    logic [NUM_FLAGS-1:0] next_irq_status;
    logic                 soft_brownout_enable;
    logic                 next_brownout_enable;
    logic                 brownout_circuit_ready;
    logic                 ext_pin_level;
    logic                 ext_pin_prev;
    logic                 ext_pin_evt;
    logic                 setup;
    logic                 access;
    logic                 wr_access;
    logic                 rd_access;
    logic                 hit_borctl;
    logic                 hit_main;
    logic                 hit_sec;
    logic                 hit_stat;
    logic                 hit_mask;
    logic                 mapped;
    logic                 wr_borctl;
    logic                 wr_main;
    logic                 wr_sec;
    logic                 wr_mask_lo;
    logic                 wr_mask_hi;
    logic [31:0]          rd_borctl;
    logic [31:0]          rd_main;
    logic [31:0]          rd_sec;
    logic [31:0]          rd_stat;
    logic [31:0]          rd_mask;
    logic [31:0]          rd_data;

    // pin inputs
    rcbc_pin_sync #(.IDLE(1'b1)) u_ext_pin (
        .clk   (CLK),
        .rst_n (RST_N),
        .pin   (EXTERNAL_RESET_PIN_N),
        .level (ext_pin_level)
    );

    rcbc_pin_sync #(.IDLE(1'b0)) u_armed (
        .clk   (CLK),
        .rst_n (RST_N),
        .pin   (BROWNOUT_CIRCUIT_ARMED),
        .level (brownout_circuit_ready)
    );

    // pin reset counts once, on the filtered falling edge
    assign ext_pin_evt = ext_pin_prev & ~ext_pin_level;

    // bus phases
    assign setup     = PSEL & ~PENABLE;
    assign access    = PSEL & PENABLE & PREADY;
    assign wr_access = access & PWRITE;
    assign rd_access = access & ~PWRITE;

    // address decode
    assign hit_borctl = idx_hit(PADDR, IDX_BROWNOUT_CONTROL);
    assign hit_main   = idx_hit(PADDR, IDX_CAUSE_MAIN);
    assign hit_sec    = idx_hit(PADDR, IDX_CAUSE_SECONDARY);
    assign hit_stat   = idx_hit(PADDR, IDX_IRQ_STATUS);
    assign hit_mask   = idx_hit(PADDR, IDX_IRQ_MASK);
    assign mapped     = hit_borctl | hit_main | hit_sec | hit_stat | hit_mask;

    assign wr_borctl  = wr_access & hit_borctl & PSTRB[0];
    assign wr_main    = wr_access & hit_main & PSTRB[0];
    assign wr_sec     = wr_access & hit_sec & PSTRB[0];
    assign wr_mask_lo = wr_access & hit_mask & PSTRB[0];
    assign wr_mask_hi = wr_access & hit_mask & PSTRB[1];

    // read views; unimplemented bits are zero
    assign rd_borctl = {24'h00_0000, soft_brownout_enable, 6'h00,
                        brownout_circuit_ready};
    assign rd_main   = {24'h00_0000, flags[F_STK_OVF:F_BROWNOUT]};
    assign rd_sec    = {29'h0000_0000, flags[F_REGULATOR], 1'b0,
                        flags[F_CFG_LATCH]};
    assign rd_stat   = {22'h00_0000, irq_status};
    assign rd_mask   = {22'h00_0000, irq_mask};

    assign rd_data = hit_borctl ? rd_borctl :
                     hit_main   ? rd_main   :
                     hit_sec    ? rd_sec    :
                     hit_stat   ? rd_stat   :
                     hit_mask   ? rd_mask   : 32'h0000_0000;

    // hardware causes; power and brown-out use the load path instead
    assign hw_evt = {CONFIG_LATCH_EVT, REGULATOR_FAULT_EVT,
                     STACK_OVERFLOW_EVT, STACK_UNDERFLOW_EVT,
                     WINDOW_VIOLATION_EVT, WATCHDOG_TIMEOUT_EVT,
                     ext_pin_evt, RESET_INSTRUCTION_EVT,
                     2'b00};
    assign irq_evt = {hw_evt[F_CFG_LATCH:F_RESET_INSN], POR_EVT, BOR_EVT};

    // power-on loads all; brown-out loads all but the power-on flag
    assign init_en  = {NUM_FLAGS{POR_EVT}}
                    | ({NUM_FLAGS{BOR_EVT}} & ~FLAG_BOR_KEEP);
    assign init_val = POR_EVT ? FLAG_POR_VAL : FLAG_BOR_VAL;

    // firmware writes; storing an active value has no other effect
    assign wr_en  = {wr_sec, wr_sec, {8{wr_main}}};
    assign wr_val = {PWDATA[SEC_CFG_LATCH_POS],
                     PWDATA[SEC_REGULATOR_POS], PWDATA[7:0]};

    genvar i;
    generate
        for (i = 0; i < NUM_FLAGS; i++) begin : g_flag
            rcbc_cause_flag #(
                .ACTIVE    (FLAG_ACTIVE[i]),
                .RESET_VAL (FLAG_POR_VAL[i])
            ) u_flag (
                .clk      (CLK),
                .rst_n    (RST_N),
                .init_en  (init_en[i]),
                .init_val (init_val[i]),
                .hw_evt   (hw_evt[i]),
                .wr_en    (wr_en[i]),
                .wr_val   (wr_val[i]),
                .flag     (flags[i])
            );
        end
    endgenerate

    // soft enable acts only in the software-controlled configuration
    assign next_brownout_enable =
        (BROWNOUT_CONFIG_FIELD == CONFIG_SOFT) ? soft_brownout_enable
                                               : BROWNOUT_CONFIG_FIELD[1];

    // read clears only the bits that were returned; new events win
    assign next_irq_status = (rd_access & hit_stat)
                           ? ((irq_status & ~PRDATA[NUM_FLAGS-1:0]) | irq_evt)
                           : (irq_status | irq_evt);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            soft_brownout_enable <= SOFT_ENABLE_RST;
        end else if (POR_EVT | BOR_EVT) begin
            soft_brownout_enable <= SOFT_ENABLE_RST;
        end else if (wr_borctl) begin
            soft_brownout_enable <= PWDATA[SOFT_ENABLE_POS];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            BROWNOUT_RESET_ENABLE <= 1'b0;
        end else begin
            BROWNOUT_RESET_ENABLE <= next_brownout_enable;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ext_pin_prev <= 1'b1;
            irq_status   <= IRQ_STAT_RST;
            IRQ          <= 1'b0;
        end else begin
            ext_pin_prev <= ext_pin_level;
            irq_status   <= next_irq_status;
            IRQ          <= |(irq_status & irq_mask);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_mask <= IRQ_MASK_RST;
        end else begin
            if (wr_mask_lo) begin
                irq_mask[7:0] <= PWDATA[7:0];
            end
            if (wr_mask_hi) begin
                irq_mask[9:8] <= PWDATA[9:8];
            end
        end
    end

    // answer is ready in the first access cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= 1'b1;
            if (setup) begin
                PRDATA  <= PWRITE ? 32'h0000_0000 : rd_data;
                PSLVERR <= ~mapped;
            end
        end
    end

    property p_soft_enable_effect;
        @(posedge CLK) disable iff (!RST_N)
        (BROWNOUT_CONFIG_FIELD == CONFIG_SOFT)
            |=> (BROWNOUT_RESET_ENABLE == $past(soft_brownout_enable));
    endproperty
    a_soft_enable_effect: assert property (p_soft_enable_effect)
        else $error("soft enable not steering brown-out reset");

    property p_soft_enable_load;
        @(posedge CLK) disable iff (!RST_N)
        (POR_EVT | BOR_EVT) |=> soft_brownout_enable ##1
            (soft_brownout_enable | $past(wr_borctl));
    endproperty
    a_soft_enable_load: assert property (p_soft_enable_load)
        else $error("soft enable not loaded by power-up");

    property p_ready_read;
        @(posedge CLK) disable iff (!RST_N)
        (setup & ~PWRITE & hit_borctl)
            |=> (PRDATA[READY_POS] == $past(brownout_circuit_ready))
                && (PRDATA[6:1] == 6'h00);
    endproperty
    a_ready_read: assert property (p_ready_read)
        else $error("ready status misread");

    property p_overflow_set;
        @(posedge CLK) disable iff (!RST_N)
        (STACK_OVERFLOW_EVT & ~POR_EVT & ~BOR_EVT) |=> flags[F_STK_OVF];
    endproperty
    a_overflow_set: assert property (p_overflow_set)
        else $error("overflow flag not set");

    property p_window_clear;
        @(posedge CLK) disable iff (!RST_N)
        (WINDOW_VIOLATION_EVT & ~POR_EVT & ~BOR_EVT) |=> !flags[F_WINDOW];
    endproperty
    a_window_clear: assert property (p_window_clear)
        else $error("window flag not cleared");

    property p_pin_clear;
        @(posedge CLK) disable iff (!RST_N)
        (ext_pin_evt & ~POR_EVT & ~BOR_EVT) |=> !flags[F_EXT_PIN];
    endproperty
    a_pin_clear: assert property (p_pin_clear)
        else $error("pin flag not cleared");

    property p_power_on;
        @(posedge CLK) disable iff (!RST_N)
        POR_EVT |=> (flags == FLAG_POR_VAL);
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("power-on load wrong");

    property p_brownout;
        @(posedge CLK) disable iff (!RST_N)
        (BOR_EVT & ~POR_EVT) |=> !flags[F_BROWNOUT]
            && (flags[F_POWER_ON] == $past(flags[F_POWER_ON]));
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("brown-out load wrong");

    property p_quiet_keeps;
        @(posedge CLK) disable iff (!RST_N)
        (~|irq_evt & ~POR_EVT & ~wr_main & ~wr_sec) |=> $stable(flags);
    endproperty
    a_quiet_keeps: assert property (p_quiet_keeps)
        else $error("flag changed without cause");

    property p_event_beats_write;
        @(posedge CLK) disable iff (!RST_N)
        (wr_main & WATCHDOG_TIMEOUT_EVT & ~POR_EVT & ~BOR_EVT)
            |=> !flags[F_WDT_TMO];
    endproperty
    a_event_beats_write: assert property (p_event_beats_write)
        else $error("write overrode hardware cause");

    property p_write_stores;
        @(posedge CLK) disable iff (!RST_N)
        (wr_main & ~|hw_evt & ~POR_EVT & ~BOR_EVT)
            |=> (flags[7:0] == $past(PWDATA[7:0]));
    endproperty
    a_write_stores: assert property (p_write_stores)
        else $error("firmware write not stored");

    property p_underflow_set;
        @(posedge CLK) disable iff (!RST_N)
        (STACK_UNDERFLOW_EVT & ~POR_EVT & ~BOR_EVT) |=> flags[F_STK_UNF];
    endproperty
    a_underflow_set: assert property (p_underflow_set)
        else $error("underflow flag not set");

    property p_insn_clear;
        @(posedge CLK) disable iff (!RST_N)
        (RESET_INSTRUCTION_EVT & ~POR_EVT & ~BOR_EVT)
            |=> !flags[F_RESET_INSN];
    endproperty
    a_insn_clear: assert property (p_insn_clear)
        else $error("instruction flag not cleared");

    property p_regulator_clear;
        @(posedge CLK) disable iff (!RST_N)
        (REGULATOR_FAULT_EVT & ~POR_EVT & ~BOR_EVT) |=> !flags[F_REGULATOR];
    endproperty
    a_regulator_clear: assert property (p_regulator_clear)
        else $error("regulator flag not cleared");

    property p_latch_set;
        @(posedge CLK) disable iff (!RST_N)
        (CONFIG_LATCH_EVT & ~POR_EVT & ~BOR_EVT) |=> flags[F_CFG_LATCH];
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("config latch flag not set");

endmodule // rcbc_reset_cause

// ==== sim/rcbc_cause_model.sv ====
`timescale 1ns/1ns
module rcbc_cause_model #(
    parameter int PIN_LOW = 8,
    parameter int WARM    = 5
) (
    input  wire logic       clk,
    input  wire logic [9:0] fire,
    input  wire logic       arm,
    output logic      [9:0] evt,
    output logic            pin_n,
    output logic            armed
);
    logic [3:0] pin_cnt;
    logic [3:0] warm_cnt;

    initial begin
        pin_cnt = 4'h0;
        warm_cnt = 4'h0;
    end

    // pin cause travels only through the pin, held low long enough
    assign evt   = fire & 10'h3f7;
    assign pin_n = (pin_cnt == 4'h0);
    assign armed = arm && (warm_cnt == WARM[3:0]);

    always @(posedge clk) begin
        if (fire[3])
            pin_cnt <= PIN_LOW[3:0];
        else if (pin_cnt != 4'h0)
            pin_cnt <= pin_cnt - 4'h1;
        // armed only after a warm-up
        if (!arm)
            warm_cnt <= 4'h0;
        else if (warm_cnt != WARM[3:0])
            warm_cnt <= warm_cnt + 4'h1;
    end
endmodule // rcbc_cause_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import rcbc_pkg::*;
    localparam logic [13:0] A_BOC  = {IDX_BROWNOUT_CONTROL, 2'b00};
    localparam logic [13:0] A_SEC  = {IDX_CAUSE_SECONDARY, 2'b00};
    localparam logic [13:0] A_MAIN = {IDX_CAUSE_MAIN, 2'b00};
    localparam logic [13:0] A_STAT = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [13:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [9:0]  INACT  = 10'h013f;

    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        irq, bre, arm, pin_n, armed;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  cfg;
    logic [9:0]  fire, evt, v;
    logic [7:0]  r;
    logic [33:0] expq[$];
    logic [33:0] mon_e;
    int          fail_count, n_tests, cycles;
    int          ks[8] = '{2, 3, 4, 5, 6, 7, 8, 9};

    rcbc_cause_model rcbc_cause_model_inst (.clk(clk), .fire(fire),
        .arm(arm), .evt(evt), .pin_n(pin_n), .armed(armed));

    rcbc_reset_cause rcbc_reset_cause_inst (.CLK(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .POR_EVT(evt[1]), .BOR_EVT(evt[0]),
        .EXTERNAL_RESET_PIN_N(pin_n), .WATCHDOG_TIMEOUT_EVT(evt[4]),
        .WINDOW_VIOLATION_EVT(evt[5]), .RESET_INSTRUCTION_EVT(evt[2]),
        .STACK_OVERFLOW_EVT(evt[7]), .STACK_UNDERFLOW_EVT(evt[6]),
        .REGULATOR_FAULT_EVT(evt[8]), .CONFIG_LATCH_EVT(evt[9]),
        .BROWNOUT_CONFIG_FIELD(cfg), .BROWNOUT_CIRCUIT_ARMED(armed),
        .BROWNOUT_RESET_ENABLE(bre), .IRQ(irq));

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        cfg = 2'h1;
        fire = 10'h000;
        arm = 1'b0;
        fail_count = 0;
        n_tests = 0;
        cycles = 0;
    end

    always #4 clk = ~clk;

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // e: care, slave error, data; f: causes raised in the access cycle
    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] d, input logic [33:0] e,
                       input logic [9:0] f);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            expq.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        fire <= f;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        fire <= 10'h000;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 34'h0, 10'h000);
    endtask

    task automatic rd(input logic [13:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, {2'b10, 24'h0, e}, 10'h000);
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        fire <= 10'h001 << k;
        @(posedge clk);
        fire <= 10'h000;
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            mon_e = expq.pop_front();
            if (mon_e[33]) begin
                check("read data", mon_e[31:0], prdata);
                check("slave error", {31'h0, mon_e[32]}, {31'h0, pslverr});
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        void'($urandom(32'h5488));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_MAIN, 8'h3d);
        rd(A_SEC, 8'h05);
        rd(A_BOC, 8'h80);
        apb(1'b0, 14'h0010, 32'h0, {2'b11, 32'h0}, 10'h000);
        foreach (ks[i]) begin
            wr(A_MAIN, INACT[7:0]);
            wr(A_SEC, {5'h0, INACT[8], 1'b0, INACT[9]});
            pulse(ks[i]);
            repeat (12) @(posedge clk);
            v = INACT ^ (10'h001 << ks[i]);
            rd(A_MAIN, v[7:0]);
            rd(A_SEC, {5'h0, v[8], 1'b0, v[9]});
        end
        repeat (4) begin
            r = 8'($urandom);
            wr(A_MAIN, r);
            rd(A_MAIN, r);
        end
        wr(A_SEC, 8'hff);
        rd(A_SEC, 8'h05);
        apb(1'b1, A_MAIN, 32'h3f, 34'h0, 10'h080);
        rd(A_MAIN, 8'hbf);
        apb(1'b1, A_MAIN, 32'h3f, 34'h0, 10'h020);
        rd(A_MAIN, 8'h1f);
        apb(1'b1, A_MAIN, 32'h3f, 34'h0, 10'h010);
        rd(A_MAIN, 8'h2f);
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 2; s++) begin
                cfg <= c[1:0];
                wr(A_BOC, {s[0], 7'h0});
                repeat (3) @(posedge clk);
                v[0] = (c == 1) ? s[0] : c[1];
                check("enable", {31'h0, v[0]}, {31'h0, bre});
                rd(A_BOC, {s[0], 7'h0});
            end
        end
        cfg <= 2'h1;
        wr(A_MAIN, 8'h02);
        wr(A_BOC, 8'h00);
        pulse(0);
        repeat (3) @(posedge clk);
        check("enable", 32'h1, {31'h0, bre});
        rd(A_MAIN, 8'h3e);
        rd(A_SEC, 8'h05);
        rd(A_BOC, 8'h80);
        wr(A_BOC, 8'h00);
        pulse(3);
        repeat (12) @(posedge clk);
        rd(A_BOC, 8'h00);
        wr(A_MAIN, 8'h02);
        pulse(1);
        repeat (2) @(posedge clk);
        rd(A_MAIN, 8'h3d);
        arm <= 1'b1;
        repeat (12) @(posedge clk);
        rd(A_BOC, 8'h81);
        apb(1'b0, A_STAT, 32'h0, 34'h0, 10'h000);
        wr(A_MASK, 8'h80);
        pulse(6);
        repeat (3) @(posedge clk);
        check("masked irq", 32'h0, {31'h0, irq});
        pulse(7);
        repeat (3) @(posedge clk);
        check("irq", 32'h1, {31'h0, irq});
        rd(A_STAT, 8'hc0);
        repeat (3) @(posedge clk);
        check("cleared irq", 32'h0, {31'h0, irq});
        results();
    end
endmodule // testbench
